// file: hw/rss_pkg.sv
// package: opcodes, flag layout and constants for the rotate/subtract/skip/set datapath
package rss_pkg;

    localparam int RSS_DATA_W = 8;

    // flag bit positions inside the flag vector
    localparam int RSS_FLAG_C  = 0;
    localparam int RSS_FLAG_AC = 1;
    localparam int RSS_FLAG_Z  = 2;
    localparam int RSS_FLAG_OV = 3;
    localparam int RSS_FLAG_SC = 4;
    localparam int RSS_FLAG_CZ = 5;
    localparam int RSS_FLAG_W  = 6;

    // reset values and other constants
    localparam logic [7:0] RSS_ACC_RST   = 8'h00;
    localparam logic [5:0] RSS_FLAGS_RST = 6'h00;
    localparam logic [7:0] RSS_SET_BYTE  = 8'hFF;
    localparam logic [7:0] RSS_ONE       = 8'h01;
    localparam logic [7:0] RSS_ZERO      = 8'h00;

    // operation selects from the instruction decoder
    typedef enum logic [2:0] {
        RSS_OP_NOP,
        RSS_OP_ROTATE_RIGHT_CARRY_INTO_ACC,
        RSS_OP_SUBTRACT_BORROW_INTO_ACC,
        RSS_OP_SUBTRACT_BORROW_INTO_MEMORY,
        RSS_OP_DECREMENT_SKIP_ZERO_MEMORY,
        RSS_OP_DECREMENT_SKIP_ZERO_ACC,
        RSS_OP_SET_BYTE,
        RSS_OP_SET_BIT
    } rss_op_t;

    // one issued instruction
    typedef struct packed {
        rss_op_t    op;
        logic [2:0] bit_sel;
        logic [7:0] mem_data;
    } rss_req_t;

    // data memory write-back
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } rss_mem_wr_t;

endpackage

// file: hw/rss_datapath.sv
// execution datapath for the rotate, subtract-with-borrow, decrement-skip and set group
`timescale 1ns/1ps

module rss_datapath
    import rss_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // instruction issue
    input  wire logic                 issue_valid,
    input  rss_pkg::rss_req_t         issue_req,
    // results
    output rss_pkg::rss_mem_wr_t      mem_wr,
    output logic [7:0]                accumulator,
    output logic [5:0]                flags,
    output logic                      skip_dummy
);
    import rss_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    function automatic logic [7:0] rotate_right_fn(
        input logic [7:0] v,
        input logic       c
    );
        return {c, v[7:1]};
    endfunction

    function automatic logic [8:0] sub_borrow_fn(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic       c
    );
        return {1'b0, a} - {1'b0, b} - {8'h00, ~c};
    endfunction

    // low nibble only, bit 4 is the half borrow
    function automatic logic [4:0] nibble_sub_fn(
        input logic [3:0] a,
        input logic [3:0] b,
        input logic       c
    );
        return {1'b0, a} - {1'b0, b} - {4'h0, ~c};
    endfunction

    function automatic logic sub_ovf_fn(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic [7:0] r
    );
        return (a[7] ^ b[7]) & (a[7] ^ r[7]);
    endfunction

    // shared by the zero flag and both skip tests
    function automatic logic is_zero_fn(
        input logic [7:0] v
    );
        return (v == RSS_ZERO);
    endfunction

    function automatic logic [7:0] decrement_fn(
        input logic [7:0] v
    );
        return v - RSS_ONE;
    endfunction

    function automatic logic [7:0] set_bit_fn(
        input logic [7:0] v,
        input logic [2:0] i
    );
        logic [7:0] r;
        r    = v;
        r[i] = 1'b1;
        return r;
    endfunction

    // positions come from the package, so the layout can move in one place
    function automatic logic [RSS_FLAG_W-1:0] pack_flags_fn(
        input logic c,
        input logic ac,
        input logic z,
        input logic ov,
        input logic sc,
        input logic cz
    );
        logic [RSS_FLAG_W-1:0] f;
        f              = '0;
        f[RSS_FLAG_C]  = c;
        f[RSS_FLAG_AC] = ac;
        f[RSS_FLAG_Z]  = z;
        f[RSS_FLAG_OV] = ov;
        f[RSS_FLAG_SC] = sc;
        f[RSS_FLAG_CZ] = cz;
        return f;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [RSS_DATA_W-1:0] acc_q;
    logic [RSS_DATA_W-1:0] acc_d;
    logic [RSS_FLAG_W-1:0] flags_q;
    logic [RSS_FLAG_W-1:0] flags_d;
    rss_mem_wr_t           mem_q;
    rss_mem_wr_t           mem_d;
    logic                  skip_q;
    logic                  skip_d;

    // ----------------------------------------------------------------
    // operation decode
    // ----------------------------------------------------------------
    // dummy cycle drops issue
    wire       go          = issue_valid & ~skip_q;
    wire       is_rot      = (issue_req.op == RSS_OP_ROTATE_RIGHT_CARRY_INTO_ACC);
    wire       is_sub_acc  = (issue_req.op == RSS_OP_SUBTRACT_BORROW_INTO_ACC);
    wire       is_sub_mem  = (issue_req.op == RSS_OP_SUBTRACT_BORROW_INTO_MEMORY);
    wire       is_dec_mem  = (issue_req.op == RSS_OP_DECREMENT_SKIP_ZERO_MEMORY);
    wire       is_dec_acc  = (issue_req.op == RSS_OP_DECREMENT_SKIP_ZERO_ACC);
    wire       is_set_byte = (issue_req.op == RSS_OP_SET_BYTE);
    wire       is_set_bit  = (issue_req.op == RSS_OP_SET_BIT);

    // qualified strobes, one per operation
    wire       do_rot      = go & is_rot;
    wire       do_sub_acc  = go & is_sub_acc;
    wire       do_sub_mem  = go & is_sub_mem;
    wire       do_sub      = do_sub_acc | do_sub_mem;
    wire       do_dec_mem  = go & is_dec_mem;
    wire       do_dec_acc  = go & is_dec_acc;
    wire       do_dec      = do_dec_mem | do_dec_acc;
    wire       do_set_byte = go & is_set_byte;
    wire       do_set_bit  = go & is_set_bit;

    // ----------------------------------------------------------------
    // operands
    // ----------------------------------------------------------------
    wire [7:0] m           = issue_req.mem_data;
    wire [2:0] bit_sel     = issue_req.bit_sel;
    wire       c_in        = flags_q[RSS_FLAG_C];
    wire [3:0] acc_lo      = acc_q[3:0];
    wire [3:0] m_lo        = m[3:0];

    // ----------------------------------------------------------------
    // rotate
    // ----------------------------------------------------------------
    // old carry on top
    wire [7:0] rot_res     = rotate_right_fn(m, c_in);
    wire       rot_c       = m[0];

    // ----------------------------------------------------------------
    // subtract with borrow
    // ----------------------------------------------------------------
    // inverted carry borrows
    wire [8:0] sub_full    = sub_borrow_fn(acc_q, m, c_in);
    wire [4:0] sub_low     = nibble_sub_fn(acc_lo, m_lo, c_in);
    wire [7:0] sub_res     = sub_full[7:0];
    wire       sub_c       = ~sub_full[8];
    wire       sub_ac      = ~sub_low[4];
    wire       sub_z       = is_zero_fn(sub_res);
    wire       sub_ov      = sub_ovf_fn(acc_q, m, sub_res);
    // no chaining: sc follows z, cz follows c
    wire       sub_sc      = sub_z;
    wire       sub_cz      = sub_c;

    // ----------------------------------------------------------------
    // decrement and skip
    // ----------------------------------------------------------------
    // one shared decrementer
    wire [7:0] dec_res     = decrement_fn(m);
    wire       dec_zero    = is_zero_fn(dec_res);

    // ----------------------------------------------------------------
    // set byte and set bit
    // ----------------------------------------------------------------
    // all bits high
    wire [7:0] set_byte_res = RSS_SET_BYTE;
    wire [7:0] set_bit_res  = set_bit_fn(m, bit_sel);

    // ----------------------------------------------------------------
    // accumulator next value
    // ----------------------------------------------------------------
    // accumulator writers
    wire       acc_wr      = do_rot | do_sub_acc | do_dec_acc;
    wire [7:0] acc_new     = do_rot     ? rot_res :
                             do_sub_acc ? sub_res :
                                          dec_res;
    assign acc_d = acc_wr ? acc_new : acc_q;

    // ----------------------------------------------------------------
    // memory write-back
    // ----------------------------------------------------------------
    // memory writers
    wire       mem_we_new  = do_sub_mem | do_dec_mem | do_set_byte | do_set_bit;
    wire [7:0] mem_data_new = do_sub_mem  ? sub_res      :
                              do_dec_mem  ? dec_res      :
                              do_set_byte ? set_byte_res :
                              do_set_bit  ? set_bit_res  :
                                            RSS_ZERO;
    assign mem_d = '{we: mem_we_new, data: mem_data_new};

    // ----------------------------------------------------------------
    // flag next value
    // ----------------------------------------------------------------
    // rotate changes carry
    wire       c_next      = do_rot ? rot_c :
                             do_sub ? sub_c :
                                      flags_q[RSS_FLAG_C];
    wire       ac_next     = do_sub ? sub_ac : flags_q[RSS_FLAG_AC];
    wire       z_next      = do_sub ? sub_z  : flags_q[RSS_FLAG_Z];
    wire       ov_next     = do_sub ? sub_ov : flags_q[RSS_FLAG_OV];
    wire       sc_next     = do_sub ? sub_sc : flags_q[RSS_FLAG_SC];
    wire       cz_next     = do_sub ? sub_cz : flags_q[RSS_FLAG_CZ];
    assign flags_d = pack_flags_fn(
        c_next,
        ac_next,
        z_next,
        ov_next,
        sc_next,
        cz_next
    );

    // ----------------------------------------------------------------
    // skip control
    // ----------------------------------------------------------------
    // skip on zero
    assign skip_d = do_dec & dec_zero;

    // ----------------------------------------------------------------
    // accumulator register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc_q <= RSS_ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    // ----------------------------------------------------------------
    // flag register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            flags_q <= RSS_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------------------------------
    // write-back register
    // ----------------------------------------------------------------
    // strobe lasts one cycle, data zero between writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mem_q <= '0;
        end else begin
            mem_q <= mem_d;
        end
    end

    // ----------------------------------------------------------------
    // skip register
    // ----------------------------------------------------------------
    // one dummy cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign accumulator = acc_q;
    assign flags       = flags_q;
    assign mem_wr      = mem_q;
    assign skip_dummy  = skip_q;

endmodule

// file: tb/rss_datapath_monitor.sv
// port checker for the rotate/subtract/skip/set datapath
`timescale 1ns/1ps
module rss_datapath_monitor
    import rss_pkg::*;
(
    // clock and reset
    input wire logic            clk_sys,
    input wire logic            reset,
    // issue side and results
    input wire logic            issue_valid,
    input rss_pkg::rss_req_t    issue_req,
    input rss_pkg::rss_mem_wr_t mem_wr,
    input wire logic [7:0]      accumulator,
    input wire logic [5:0]      flags,
    input wire logic            skip_dummy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // issue counts only outside the dummy cycle
    wire logic       tk = issue_valid && !skip_dummy;
    wire logic [2:0] op = issue_req.op;
    wire logic [7:0] m  = issue_req.mem_data;
    wire logic [8:0] df = {1'b0, accumulator} - {1'b0, m} - {8'h00, ~flags[0]};
    wire logic       ov = (accumulator[7] ^ m[7]) & (df[7] ^ accumulator[7]);
    // codes 2 and 3 are the two subtracts
    wire logic       sb = tk && op[2:1] == 2'b01;
    a_rotate_carry: assert property (tk && op == RSS_OP_ROTATE_RIGHT_CARRY_INTO_ACC |=>
        accumulator == {$past(flags[0]), $past(m[7:1])} && flags == {$past(flags[5:1]), $past(m[0])}
        && !mem_wr.we) else $error("rotate result wrong");
    a_sub_acc: assert property (sb && op == RSS_OP_SUBTRACT_BORROW_INTO_ACC |=>
        accumulator == $past(df[7:0]) && !mem_wr.we) else $error("subtract to acc wrong");
    a_sub_mem: assert property (sb && op == RSS_OP_SUBTRACT_BORROW_INTO_MEMORY |=>
        mem_wr.we && mem_wr.data == $past(df[7:0]) && $stable(accumulator))
        else $error("subtract to memory wrong");
    a_sub_flags: assert property (sb |=> flags[0] == !$past(df[8]) && flags[3] == $past(ov)
        && flags[2] == ($past(df[7:0]) == 8'h00) && flags[4] == flags[2] && flags[5] == flags[0])
        else $error("subtract flags wrong");
    a_dec_memory: assert property (tk && op == RSS_OP_DECREMENT_SKIP_ZERO_MEMORY |=>
        mem_wr.we && mem_wr.data == $past(m) - 8'h01 && skip_dummy == (mem_wr.data == 8'h00)
        && $stable(flags)) else $error("decrement to memory wrong");
    a_dec_acc: assert property (tk && op == RSS_OP_DECREMENT_SKIP_ZERO_ACC |=>
        accumulator == $past(m) - 8'h01 && skip_dummy == (accumulator == 8'h00) && !mem_wr.we
        && $stable(flags)) else $error("decrement to acc wrong");
    a_skip_drop: assert property (skip_dummy |=> !skip_dummy && !mem_wr.we
        && $stable(accumulator) && $stable(flags)) else $error("skipped issue acted");
    a_set_byte: assert property (tk && op == RSS_OP_SET_BYTE |=>
        mem_wr.we && mem_wr.data == 8'hFF && $stable(flags)) else $error("set byte wrong");
    a_set_bit: assert property (tk && op == RSS_OP_SET_BIT |=> mem_wr.we && $stable(flags)
        && mem_wr.data == ($past(m) | (8'h01 << $past(issue_req.bit_sel)))) else $error("set bit wrong");
endmodule
bind rss_datapath rss_datapath_monitor rss_datapath_monitor_i (.clk_sys, .reset, .issue_valid,
    .issue_req, .mem_wr, .accumulator, .flags, .skip_dummy);

// file: tb/rss_datapath_test.sv
// self-checking bench for the rotate/subtract/skip/set datapath
`timescale 1ns/1ps
module rss_datapath_test;
    import rss_pkg::*;
    typedef struct packed {logic [2:0] op, bs; logic [7:0] m; logic [31:0] e;} rss_row_t;
    logic        clk_sys, reset, issue_valid;
    rss_req_t    issue_req;
    rss_mem_wr_t mem_wr;
    logic [7:0]  accumulator;
    logic [5:0]  flags;
    logic        skip_dummy;
    int          error_cnt = 0;
    int          checks_done = 0;
    // packed view: acc, flags, written byte, we nibble, skip nibble
    wire logic [31:0] outs = {accumulator, 2'b00, flags, mem_wr.data & {8{mem_wr.we}},
                              3'b000, mem_wr.we, 3'b000, skip_dummy};
    rss_row_t rows [11] = '{
        '{3'h1, 3'h0, 8'h03, 32'h01_01_00_00}, '{3'h1, 3'h0, 8'h02, 32'h81_00_00_00},
        '{3'h2, 3'h0, 8'h80, 32'h00_37_00_00}, '{3'h2, 3'h0, 8'h01, 32'hFF_00_00_00},
        '{3'h3, 3'h0, 8'h7F, 32'hFF_29_7F_10}, '{3'h2, 3'h0, 8'h80, 32'h7F_23_00_00},
        '{3'h6, 3'h0, 8'h12, 32'h7F_23_FF_10}, '{3'h7, 3'h0, 8'h40, 32'h7F_23_41_10},
        '{3'h4, 3'h0, 8'h00, 32'h7F_23_FF_10}, '{3'h5, 3'h0, 8'h10, 32'h0F_23_00_00},
        '{3'h0, 3'h0, 8'h55, 32'h0F_23_00_00}};
    rss_datapath rss_datapath_i (.clk_sys, .reset, .issue_valid, .issue_req, .mem_wr,
        .accumulator, .flags, .skip_dummy);
    task automatic issue(input logic [2:0] op, bs, input logic [7:0] m);
        @(posedge clk_sys);
        issue_valid <= 1'b1;
        issue_req <= '{rss_op_t'(op), bs, m};
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        #1;
    endtask
    task automatic cmp(input logic [31:0] exp);
        checks_done++;
        if (outs !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, outs, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // run takes about 48 cycles
    initial begin
        #5000;
        error_cnt++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        issue_valid = 1'b0;
        issue_req = '0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        #1 cmp(32'h0);
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].bs, rows[i].m);
            cmp(rows[i].e);
        end
        // skip with a back-to-back issue that must be dropped
        @(posedge clk_sys);
        issue_valid <= 1'b1;
        issue_req <= '{RSS_OP_DECREMENT_SKIP_ZERO_MEMORY, 3'h0, 8'h01};
        @(posedge clk_sys);
        issue_req <= '{RSS_OP_SET_BYTE, 3'h0, 8'h00};
        #1 cmp(32'h0F_23_00_11);
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        #1 cmp(32'h0F_23_00_00);
        issue(3'h5, 3'h0, 8'h01);
        cmp(32'h00_23_00_01);
        for (int i = 0; i < 8; i++) begin
            issue(3'h7, 3'(i), ~(8'h01 << i));
            cmp(32'h00_23_FF_10);
        end
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        #1 cmp(32'h0);
        conclude();
    end
endmodule
